// ### design/rss_pkg.sv
//------------------------------------------------------------
// reset source and start-up sequencer constants
//------------------------------------------------------------
package rss_pkg;
	//------------------------------------------------------------
	// timing
	//------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100; // 10 MHz system clock
	localparam int unsigned POWERUP_TIMER_NOMINAL_NS = 66_000_000; // nominal 66 ms
	localparam int unsigned POWERUP_TIMER_LF_CYCLES = 2048; // slow oscillator cycles
	// one slow oscillator period, in system clocks (nominal, rounded down)
	localparam int unsigned LF_DIV_CYCLES = (POWERUP_TIMER_NOMINAL_NS / POWERUP_TIMER_LF_CYCLES) / CLK_PERIOD_NS;
	localparam int unsigned MASTER_CLEAR_PIN_FILTER_NS = 1000; // pulse rejection time
	localparam int unsigned MASTER_CLEAR_PIN_FILTER_CYCLES = (MASTER_CLEAR_PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BOR_FILTER_NS = 1000; // supply dip rejection time
	localparam int unsigned BOR_FILTER_CYCLES = (BOR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RUN_DELAY_CYCLES = 10; // clocks after pin release
	localparam int unsigned ERASE_THRESH_MV = 2450; // forced erase threshold
	localparam int unsigned DIV_W = 16; // slow-tick divider width
	localparam int unsigned POWERUP_TIMER_W = 12; // power-up tick counter width
	localparam int unsigned DLY_W = 4; // release delay counter width
	//------------------------------------------------------------
	// brown-out mode codes
	//------------------------------------------------------------
	localparam logic [1:0] BOR_MODE_ON = 2'h3; // always on
	localparam logic [1:0] BOR_MODE_SLEEP_OFF = 2'h2; // off in sleep
	localparam logic [1:0] BOR_MODE_SW = 2'h1; // software controlled
	localparam logic [1:0] BOR_MODE_OFF = 2'h0; // disabled
	//------------------------------------------------------------
	// reset cause register layout (active-low flags except stack)
	//------------------------------------------------------------
	localparam int unsigned FLG_STACK_OVERFLOW_FLAG = 7; // stack overflow, high active
	localparam int unsigned FLG_STACK_UNDERFLOW_FLAG = 6; // stack underflow, high active
	localparam int unsigned FLG_WINDOW_VIOLATION_FLAG = 5; // window violation, low active
	localparam int unsigned FLG_WATCHDOG_RESET_FLAG = 4; // watchdog timeout, low active
	localparam int unsigned FLG_MASTER_CLEAR_FLAG = 3; // master clear, low active
	localparam int unsigned FLG_RI = 2; // reset instruction, low active
	localparam int unsigned FLG_POR = 1; // power-on, low active
	localparam int unsigned FLG_BOR = 0; // brown-out, low active
	localparam logic [7:0] FLAGS_POR = 8'h3D; // unknown brown-out bit reads 1
	localparam logic [7:0] FLAGS_BOR_VAL = 8'h3C; // forced bits on brown-out
	localparam logic [7:0] FLAGS_BOR_KEEP = 8'h02; // power-on bit kept
	//------------------------------------------------------------
	// carriers
	//------------------------------------------------------------
	typedef struct packed {
		logic [1:0] brownout_mode_cfg; // monitor mode
		logic low_power_brownout_cfg; // low-power monitor enable
		logic master_clear_cfg; // master clear enable
		logic low_voltage_program_cfg; // lvp forces master clear
		logic stack_reset_cfg; // stack faults reset
		logic powerup_timer_cfg_n; // low enables power-up timer
		logic osc_startup_req; // oscillator start-up timer needed
	} rss_cfg_t;
	typedef struct packed {
		logic wdt_timeout; // watchdog period expired
		logic wdt_window_viol; // clear outside window
		logic reset_instr; // reset instruction executed
		logic stack_ovf; // stack overflow
		logic stack_unf; // stack underflow
		logic prog_exit; // programming mode left
		logic sleep_enter; // sleep instruction
		logic wake; // wake-up source
		logic watchdog_clear_instr; // watchdog clear executed
	} rss_evt_t;
	typedef enum logic [3:0] {
		ST_COLD, ST_BOR_WAIT, ST_POWERUP_TIMER, ST_OST, ST_MASTER_CLEAR_PIN_HOLD,
		ST_RUN_DELAY, ST_RUN, ST_SLEEP, ST_WAKE_WAIT, ST_WARM
	} rss_state_t;
endpackage : rss_pkg

// ### design/rss_glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// level filter: output follows input once stable long enough
//------------------------------------------------------------
module rss_glitch_filter #(
	parameter int unsigned CYCLES = 10, // stable cycles required
	parameter logic RESET_VAL = 1'b1 // output during reset
) (
	input wire logic clk_i, // system clock
	input wire logic reset_i, // async reset, high
	input wire logic raw_i, // unfiltered level
	output var logic filt_o // filtered level
);
	localparam int unsigned CW = $clog2(CYCLES + 1); // counter width
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1); // final count
	logic [CW-1:0] cnt_reg; // cycles input has differed
	wire differ = raw_i != filt_o; // candidate change
	// short pulses restart the count, so they never reach the output
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_reg <= '0;
			filt_o <= RESET_VAL;
		end else if (!differ) begin
			cnt_reg <= '0;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= '0;
			filt_o <= raw_i;
		end else begin
			cnt_reg <= cnt_reg + CW'(1);
		end
	end
endmodule : rss_glitch_filter
`default_nettype wire

// ### design/rss_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// reset source and start-up sequencer
//------------------------------------------------------------
module rss_sequencer #(
	parameter int unsigned LF_DIV = rss_pkg::LF_DIV_CYCLES, // clocks per slow tick
	parameter int unsigned POWERUP_TIMER_TICKS = rss_pkg::POWERUP_TIMER_LF_CYCLES // slow ticks held
) (
	input wire logic clk_i, // system clock
	input wire logic reset_i, // async reset, high
	input wire rss_pkg::rss_cfg_t cfg_i, // configuration words
	input wire rss_pkg::rss_evt_t evt_i, // core events, one-cycle pulses
	input wire logic por_active_i, // power-on comparator holds
	input wire logic supply_low_i, // main monitor below threshold
	input wire logic lp_supply_low_i, // low-power monitor below threshold
	input wire logic monitor_ready_i, // main monitor warmed up
	input wire logic master_clear_pin_i, // external reset pin level
	input wire logic ost_done_i, // oscillator start-up done
	input wire logic bulk_erase_i, // flash bulk erase running
	input wire logic sw_bor_wr_i, // write software enable
	input wire logic sw_bor_wdata_i, // software enable data
	input wire logic flag_wr_i, // write reset cause register
	input wire logic [7:0] flag_wdata_i, // reset cause data
	input wire logic sw_pullup_i, // software pull-up request
	output var logic cpu_run_o, // core executes
	output var logic reset_hold_o, // core held in reset
	output var logic monitor_enable_o, // main monitor powered
	output var logic erase_thresh_sel_o, // use forced erase threshold
	output var logic erase_abort_o, // abort bulk erase
	output var logic brownout_reset_o, // combined brown-out request
	output var logic brownout_ready_o, // monitor armed status
	output var logic sw_brownout_enable_o, // software enable bit
	output var logic [7:0] reset_cause_register_o, // reset cause flags
	output var logic expiry_flag_n_o, // low after watchdog expiry
	output var logic sleep_entry_flag_n_o, // low after sleep entry
	output var logic master_clear_enabled_o, // pin acts as reset
	output var logic master_clear_pullup_o, // weak pull-up on pin
	output var logic powerup_timer_busy_o // power-up timer counting
);
	//------------------------------------------------------------
	// state and counters
	//------------------------------------------------------------
	localparam logic [rss_pkg::DIV_W-1:0] DIV_LAST = rss_pkg::DIV_W'(LF_DIV - 1);
	localparam logic [rss_pkg::POWERUP_TIMER_W-1:0] POWERUP_TIMER_LAST = rss_pkg::POWERUP_TIMER_W'(POWERUP_TIMER_TICKS - 1);
	localparam logic [rss_pkg::DLY_W-1:0] DLY_LAST = rss_pkg::DLY_W'(rss_pkg::RUN_DELAY_CYCLES - 1);
	rss_pkg::rss_state_t state_reg, state_next; // sequencer state
	logic [rss_pkg::DIV_W-1:0] div_reg; // slow tick divider
	logic [rss_pkg::POWERUP_TIMER_W-1:0] powerup_timer_reg; // slow ticks elapsed
	logic [rss_pkg::DLY_W-1:0] dly_reg; // release delay count
	logic [7:0] flags_reg, flags_next; // reset cause flags
	logic sw_en_reg, sw_en_next; // software monitor enable
	logic to_n_reg, to_n_next; // expiry flag, low active
	logic pd_n_reg, pd_n_next; // sleep entry flag, low active
	logic supply_low_f; // filtered supply comparator
	logic pin_f; // filtered pin level
	//------------------------------------------------------------
	// filters
	//------------------------------------------------------------
	// noise filter on the reset pin: short pulses never reach the core
	rss_glitch_filter #(.CYCLES(rss_pkg::MASTER_CLEAR_PIN_FILTER_CYCLES), .RESET_VAL(1'b1)) u_pin_filt (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.raw_i(master_clear_pin_i),
		.filt_o(pin_f)
	);
	// supply dips shorter than the filter time do not reset
	rss_glitch_filter #(.CYCLES(rss_pkg::BOR_FILTER_CYCLES), .RESET_VAL(1'b0)) u_bor_filt (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.raw_i(supply_low_i),
		.filt_o(supply_low_f)
	);
	//------------------------------------------------------------
	// decode
	//------------------------------------------------------------
	wire [1:0] mode = cfg_i.brownout_mode_cfg; // monitor mode
	wire asleep = state_reg == rss_pkg::ST_SLEEP || state_reg == rss_pkg::ST_WAKE_WAIT;
	wire in_run = state_reg == rss_pkg::ST_RUN; // core executing
	// software bit only counts in mode 01; mode 00 keeps it off outside bulk erase
	wire mon_on = bulk_erase_i
		| (mode == rss_pkg::BOR_MODE_ON)
		| (mode == rss_pkg::BOR_MODE_SLEEP_OFF && !asleep)
		| (mode == rss_pkg::BOR_MODE_SW && sw_en_reg);
	// protection starts once the monitor is armed; erase aborts instead
	wire main_req = mon_on && monitor_ready_i && supply_low_f && !bulk_erase_i;
	wire lp_req = cfg_i.low_power_brownout_cfg && lp_supply_low_i;
	wire bor_any = main_req | lp_req;
	wire cold_por = por_active_i | evt_i.prog_exit;
	wire cold = cold_por | bor_any; // restart the full sequence
	wire master_clear_pin_en = cfg_i.low_voltage_program_cfg | cfg_i.master_clear_cfg;
	wire master_clear_pin_assert = master_clear_pin_en && !pin_f;
	// timers run on while the pin is low; only these states see the pin
	wire master_clear_pin_live = in_run || asleep || state_reg == rss_pkg::ST_RUN_DELAY
		|| state_reg == rss_pkg::ST_WARM;
	wire master_clear_pin_evt = master_clear_pin_assert && master_clear_pin_live && !cold;
	wire stack_rst = cfg_i.stack_reset_cfg && (evt_i.stack_ovf || evt_i.stack_unf);
	wire warm_evt = in_run && !cold && !master_clear_pin_assert && (evt_i.wdt_timeout
		|| evt_i.wdt_window_viol || evt_i.reset_instr || stack_rst);
	wire mode_waits = mode == rss_pkg::BOR_MODE_ON || mode == rss_pkg::BOR_MODE_SLEEP_OFF;
	wire bor_ok = monitor_ready_i && !supply_low_f; // monitor armed, supply good
	wire lf_tick = div_reg == DIV_LAST; // one slow oscillator period
	wire powerup_timer_done = lf_tick && powerup_timer_reg == POWERUP_TIMER_LAST;
	wire dly_done = dly_reg == DLY_LAST;
	wire sleep_wake = evt_i.wake || evt_i.wdt_timeout; // watchdog wakes a sleeper
	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	// cold sources win over everything, then the pin, then local steps
	always_comb begin
		state_next = state_reg;
		if (cold) begin
			state_next = rss_pkg::ST_COLD;
		end else if (master_clear_pin_evt) begin
			state_next = rss_pkg::ST_MASTER_CLEAR_PIN_HOLD;
		end else begin
			case (state_reg)
				rss_pkg::ST_COLD: state_next = rss_pkg::ST_BOR_WAIT;
				rss_pkg::ST_BOR_WAIT: begin
					if (!mode_waits || bor_ok) state_next = rss_pkg::ST_POWERUP_TIMER;
				end
				rss_pkg::ST_POWERUP_TIMER: begin
					if (cfg_i.powerup_timer_cfg_n || powerup_timer_done) state_next = rss_pkg::ST_OST;
				end
				rss_pkg::ST_OST: begin
					if (!cfg_i.osc_startup_req || ost_done_i) begin
						state_next = master_clear_pin_assert ? rss_pkg::ST_MASTER_CLEAR_PIN_HOLD : rss_pkg::ST_RUN;
					end
				end
				rss_pkg::ST_MASTER_CLEAR_PIN_HOLD: begin
					if (!master_clear_pin_assert) state_next = rss_pkg::ST_RUN_DELAY;
				end
				rss_pkg::ST_RUN_DELAY: begin
					if (dly_done) state_next = rss_pkg::ST_RUN;
				end
				rss_pkg::ST_RUN: begin
					if (warm_evt) state_next = rss_pkg::ST_WARM;
					else if (evt_i.sleep_enter) state_next = rss_pkg::ST_SLEEP;
				end
				rss_pkg::ST_SLEEP: begin
					if (sleep_wake) begin
						state_next = (mode == rss_pkg::BOR_MODE_SLEEP_OFF)
							? rss_pkg::ST_WAKE_WAIT : rss_pkg::ST_RUN;
					end
				end
				rss_pkg::ST_WAKE_WAIT: begin
					if (monitor_ready_i) state_next = rss_pkg::ST_RUN;
				end
				rss_pkg::ST_WARM: state_next = rss_pkg::ST_RUN;
				default: state_next = rss_pkg::ST_COLD;
			endcase
		end
	end
	//------------------------------------------------------------
	// flag updates
	//------------------------------------------------------------
	// software write first, hardware events after, so an event is never lost
	always_comb begin
		flags_next = flag_wr_i ? flag_wdata_i : flags_reg;
		sw_en_next = sw_bor_wr_i ? sw_bor_wdata_i : sw_en_reg;
		to_n_next = to_n_reg;
		pd_n_next = pd_n_reg;
		if (cold_por) begin
			flags_next = rss_pkg::FLAGS_POR;
			sw_en_next = 1'b1;
			to_n_next = 1'b1;
			pd_n_next = 1'b1;
		end else if (bor_any) begin
			flags_next = (flags_reg & rss_pkg::FLAGS_BOR_KEEP) | rss_pkg::FLAGS_BOR_VAL;
			sw_en_next = 1'b1;
			to_n_next = 1'b1;
			pd_n_next = 1'b1;
		end else if (master_clear_pin_evt) begin
			flags_next[rss_pkg::FLG_MASTER_CLEAR_FLAG] = 1'b0;
			if (asleep) begin
				to_n_next = 1'b1;
				pd_n_next = 1'b0;
			end
		end else if (in_run) begin
			if (evt_i.wdt_timeout) begin
				flags_next[rss_pkg::FLG_WATCHDOG_RESET_FLAG] = 1'b0;
				to_n_next = 1'b0;
			end
			if (evt_i.wdt_window_viol) flags_next[rss_pkg::FLG_WINDOW_VIOLATION_FLAG] = 1'b0;
			if (evt_i.reset_instr) flags_next[rss_pkg::FLG_RI] = 1'b0;
			if (cfg_i.stack_reset_cfg && evt_i.stack_ovf) flags_next[rss_pkg::FLG_STACK_OVERFLOW_FLAG] = 1'b1;
			if (cfg_i.stack_reset_cfg && evt_i.stack_unf) flags_next[rss_pkg::FLG_STACK_UNDERFLOW_FLAG] = 1'b1;
			if (evt_i.watchdog_clear_instr) begin
				to_n_next = 1'b1;
				pd_n_next = 1'b1;
			end else if (evt_i.sleep_enter && !warm_evt) begin
				to_n_next = 1'b1;
				pd_n_next = 1'b0;
			end
		end else if (state_reg == rss_pkg::ST_SLEEP && evt_i.wdt_timeout) begin
			to_n_next = 1'b0;
			pd_n_next = 1'b0;
		end
	end
	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	// sequencer state
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) state_reg <= rss_pkg::ST_COLD;
		else state_reg <= state_next;
	end
	// slow tick divider and power-up count, idle outside the timer state
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_reg <= '0;
			powerup_timer_reg <= '0;
		end else if (state_reg != rss_pkg::ST_POWERUP_TIMER) begin
			div_reg <= '0;
			powerup_timer_reg <= '0;
		end else if (lf_tick) begin
			div_reg <= '0;
			powerup_timer_reg <= powerup_timer_reg + rss_pkg::POWERUP_TIMER_W'(1);
		end else begin
			div_reg <= div_reg + rss_pkg::DIV_W'(1);
		end
	end
	// release delay after the pin goes high
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) dly_reg <= '0;
		else if (state_reg != rss_pkg::ST_RUN_DELAY) dly_reg <= '0;
		else dly_reg <= dly_reg + rss_pkg::DLY_W'(1);
	end
	// software-visible flags
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			flags_reg <= rss_pkg::FLAGS_POR;
			sw_en_reg <= 1'b1;
			to_n_reg <= 1'b1;
			pd_n_reg <= 1'b1;
		end else begin
			flags_reg <= flags_next;
			sw_en_reg <= sw_en_next;
			to_n_reg <= to_n_next;
			pd_n_reg <= pd_n_next;
		end
	end
	// output flops, loaded from next values so they match the state
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cpu_run_o <= 1'b0;
			reset_hold_o <= 1'b1;
			powerup_timer_busy_o <= 1'b0;
		end else begin
			cpu_run_o <= state_next == rss_pkg::ST_RUN;
			reset_hold_o <= !(state_next == rss_pkg::ST_RUN || state_next == rss_pkg::ST_SLEEP
				|| state_next == rss_pkg::ST_WAKE_WAIT);
			powerup_timer_busy_o <= state_next == rss_pkg::ST_POWERUP_TIMER;
		end
	end
	// monitor and pin controls; the pin has no driver, only a pull-up
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			monitor_enable_o <= 1'b0;
			erase_thresh_sel_o <= 1'b0;
			erase_abort_o <= 1'b0;
			brownout_reset_o <= 1'b0;
			brownout_ready_o <= 1'b0;
			master_clear_enabled_o <= 1'b0;
			master_clear_pullup_o <= 1'b0;
		end else begin
			monitor_enable_o <= mon_on;
			erase_thresh_sel_o <= bulk_erase_i;
			erase_abort_o <= bulk_erase_i && monitor_ready_i && supply_low_f;
			brownout_reset_o <= bor_any;
			brownout_ready_o <= mon_on && monitor_ready_i;
			master_clear_enabled_o <= master_clear_pin_en;
			master_clear_pullup_o <= master_clear_pin_en || sw_pullup_i;
		end
	end
	assign sw_brownout_enable_o = sw_en_reg;
	assign reset_cause_register_o = flags_reg;
	assign expiry_flag_n_o = to_n_reg;
	assign sleep_entry_flag_n_o = pd_n_reg;
	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	// dwell count in the release delay, kept apart from the sequencing counter
	logic [rss_pkg::DLY_W-1:0] chk_dly_reg; // cycles spent in the release delay
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) chk_dly_reg <= '0;
		else if (state_reg == rss_pkg::ST_RUN_DELAY)
			chk_dly_reg <= chk_dly_reg + rss_pkg::DLY_W'(1);
		else chk_dly_reg <= '0;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_mode_on_monitor: assert property (mode == rss_pkg::BOR_MODE_ON |=> monitor_enable_o)
		else $error("monitor off in always-on mode");
	a_sleep_off_mon: assert property (mode == rss_pkg::BOR_MODE_SLEEP_OFF && asleep
		&& !bulk_erase_i |=> !monitor_enable_o)
		else $error("monitor on during sleep in mode 10");
	a_wake_wait_ready: assert property (state_reg == rss_pkg::ST_WAKE_WAIT
		&& !monitor_ready_i && !cold && !master_clear_pin_evt |=> !cpu_run_o)
		else $error("woke before monitor ready");
	a_wake_no_delay: assert property (state_reg == rss_pkg::ST_SLEEP && sleep_wake
		&& !cold && !master_clear_pin_evt && mode == rss_pkg::BOR_MODE_ON |=> cpu_run_o)
		else $error("wake delayed in always-on mode");
	a_off_mode_mon: assert property (mode == rss_pkg::BOR_MODE_OFF && !bulk_erase_i
		|=> !monitor_enable_o)
		else $error("monitor on in disabled mode");
	a_erase_no_reset: assert property (bulk_erase_i && in_run && !lp_req && !cold_por
		&& !warm_evt && !master_clear_pin_evt && !evt_i.sleep_enter |=> cpu_run_o)
		else $error("bulk erase dip reset the core");
	a_lp_combined: assert property (lp_req |=> brownout_reset_o ##1 !cpu_run_o)
		else $error("low-power request lost");
	a_master_clear_pin_flag: assert property (master_clear_pin_evt
		|=> !reset_cause_register_o[rss_pkg::FLG_MASTER_CLEAR_FLAG] && reset_hold_o)
		else $error("master clear flag not cleared");
	a_ri_flag: assert property (warm_evt && evt_i.reset_instr
		|=> !reset_cause_register_o[rss_pkg::FLG_RI] && !cpu_run_o)
		else $error("reset instruction not recorded");
	a_stack_gate: assert property (in_run && !cfg_i.stack_reset_cfg && evt_i.stack_ovf
		&& !cold && !flag_wr_i |=> $stable(reset_cause_register_o[rss_pkg::FLG_STACK_OVERFLOW_FLAG]))
		else $error("stack flag set while disabled");
	a_powerup_timer_hold: assert property (state_reg == rss_pkg::ST_POWERUP_TIMER
		|-> reset_hold_o && powerup_timer_busy_o)
		else $error("core released during power-up timer");
	a_run_delay: assert property ($rose(cpu_run_o)
		&& $past(state_reg) == rss_pkg::ST_RUN_DELAY |-> $past(chk_dly_reg) == DLY_LAST)
		else $error("release delay wrong length");
	a_delay_hold: assert property (state_reg == rss_pkg::ST_RUN_DELAY |-> !cpu_run_o)
		else $error("core ran inside release delay");
	a_flag_sticky: assert property (in_run && !cold && !flag_wr_i && !warm_evt
		&& !master_clear_pin_evt |=> $stable(reset_cause_register_o))
		else $error("flags changed without cause");
	c_cold_to_run: cover property ($fell(reset_hold_o) && cpu_run_o);
	c_pin_release: cover property (state_reg == rss_pkg::ST_RUN_DELAY ##1 cpu_run_o);
	c_wake_wait: cover property (state_reg == rss_pkg::ST_WAKE_WAIT ##1 cpu_run_o);
	c_warm_reset: cover property (warm_evt ##2 cpu_run_o);
endmodule : rss_sequencer
`default_nettype wire

// ### dv/rss_far_model.sv
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// far side: reset pin with weak pull-up and supply monitor
//------------------------------------------------------------
module rss_far_model (
	input wire logic clk_i, // system clock
	input wire logic pin_pull_i, // bench pulls the pin low
	output var logic pin_o, // level on the pin
	output var logic ready_o // main monitor armed
);
	logic [2:0] warm_reg = 3'h0; // warm-up delay, not instant like an ideal part
	// nobody drives high: the weak pull-up lifts a released pin
	assign pin_o = !pin_pull_i;
	assign ready_o = warm_reg[2];
	// monitor arms some clocks after power is up
	always_ff @(posedge clk_i) begin
		warm_reg <= {warm_reg[1:0], 1'b1};
	end
endmodule : rss_far_model
`default_nettype wire

// ### dv/reset_source_and_startup_seq_bench.sv
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// bench: cold start, internal resets, pin release timing
//------------------------------------------------------------
module reset_source_and_startup_seq_bench;
	logic clk_i = 1'b0, reset_i = 1'b1, por = 1'b1, pull = 1'b0, fwr = 1'b0;
	logic [7:0] fdat = 8'h00, flags;
	logic [8:0] evt = 9'h000; // one-cycle core events
	rss_pkg::rss_cfg_t cfg = 8'hC0; // mode 11, timer on
	int num_errors = 0, comparisons = 0, cycles = 0, n;
	logic sl = 1'b0, lpl = 1'b0, swwr = 1'b0, swd = 1'b0, pu = 1'b0, ers = 1'b0; // monitor, erase, sw
	wire logic pin, rdy, run, swen, mce, busy;
	wire logic rh, mon, ets, abt, bro, brdy, ton, pdn, pup; // observed controls and flags
	always #50 clk_i = !clk_i;
	rss_far_model far (.clk_i(clk_i), .pin_pull_i(pull), .pin_o(pin), .ready_o(rdy));
	rss_sequencer #(.LF_DIV(2), .POWERUP_TIMER_TICKS(4)) dut (.clk_i(clk_i), .reset_i(reset_i),
		.cfg_i(cfg), .evt_i(evt), .por_active_i(por), .supply_low_i(sl),
		.lp_supply_low_i(lpl), .monitor_ready_i(rdy), .master_clear_pin_i(pin),
		.ost_done_i(1'b1), .bulk_erase_i(ers), .sw_bor_wr_i(swwr), .sw_bor_wdata_i(swd),
		.flag_wr_i(fwr), .flag_wdata_i(fdat), .sw_pullup_i(pu), .cpu_run_o(run),
		.reset_hold_o(rh), .monitor_enable_o(mon), .erase_thresh_sel_o(ets), .erase_abort_o(abt),
		.brownout_reset_o(bro), .brownout_ready_o(brdy), .sw_brownout_enable_o(swen),
		.reset_cause_register_o(flags), .expiry_flag_n_o(ton), .sleep_entry_flag_n_o(pdn),
		.master_clear_enabled_o(mce), .master_clear_pullup_o(pup), .powerup_timer_busy_o(busy));
	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// bounded wait for the core to run
	task wait_run();
		for (int i = 0; i < 500 && run !== 1'b1; i++) @(negedge clk_i);
		chk(run, 1'b1);
	endtask : wait_run
	task pulse(input logic [8:0] v);
		evt = v;
		@(negedge clk_i);
		evt = 9'h000;
	endtask : pulse
	task t_cold();
		repeat (6) @(negedge clk_i);
		reset_i = 1'b0;
		por = 1'b0;
		wait_run();
		chk(flags, rss_pkg::FLAGS_POR);
		chk(swen, 1'b1);
		$display("cold start done");
	endtask : t_cold
	task t_instr();
		pulse(9'h040);
		wait_run();
		chk(flags, 8'h39);
		fdat = 8'h3D;
		fwr = 1'b1;
		@(negedge clk_i);
		fwr = 1'b0;
		@(negedge clk_i);
		chk(flags, 8'h3D);
		pulse(9'h020);
		repeat (3) @(negedge clk_i);
		chk({flags[7], run}, 2'h1);
		cfg.stack_reset_cfg = 1'b1;
		pulse(9'h020);
		wait_run();
		chk(flags, 8'hBD);
		$display("internal resets done");
	endtask : t_instr
	task t_pin();
		for (int i = 0; i < 4; i++) begin
			{cfg.low_voltage_program_cfg, cfg.master_clear_cfg} = 2'(i);
			repeat (2) @(negedge clk_i);
			chk(mce, i != 0);
		end
		pull = 1'b1;
		pulse(9'h004);
		repeat (40) @(negedge clk_i);
		chk({run, busy}, 2'h0);
		chk({ton, pdn}, 2'h2);
		pull = 1'b0;
		for (n = 0; n < 60 && run !== 1'b1; n++) @(negedge clk_i);
		chk(n >= 20 && n <= 23, 1'b1);
		$display("pin release done");
	endtask : t_pin
	// supply dips, bulk erase, both brown-out paths, software enable, pull-up
	task t_bor();
		chk(pup, 1'b1);
		// a dip shorter than the filter must not reset
		sl = 1'b1;
		repeat (5) @(negedge clk_i);
		sl = 1'b0;
		repeat (12) @(negedge clk_i);
		chk(run, 1'b1);
		chk(flags, 8'hB5);
		// erase: forced threshold, abort, core keeps running
		ers = 1'b1;
		sl = 1'b1;
		repeat (14) @(negedge clk_i);
		chk({abt, ets, run}, 3'h7);
		sl = 1'b0;
		repeat (14) @(negedge clk_i);
		ers = 1'b0;
		@(negedge clk_i);
		chk({abt, ets, run}, 3'h1);
		// main monitor brown-out restarts the sequence
		sl = 1'b1;
		repeat (12) @(negedge clk_i);
		chk({run, rh, bro}, 3'h3);
		chk(flags, 8'h3C);
		sl = 1'b0;
		wait_run();
		// low-power monitor ignored until configured
		lpl = 1'b1;
		repeat (2) @(negedge clk_i);
		chk({run, bro}, 2'h2);
		fdat = 8'hC3;
		fwr = 1'b1;
		@(negedge clk_i);
		fwr = 1'b0;
		cfg.low_power_brownout_cfg = 1'b1;
		@(negedge clk_i);
		chk({run, bro}, 2'h1);
		chk(flags, 8'h3E);
		lpl = 1'b0;
		cfg.low_power_brownout_cfg = 1'b0;
		wait_run();
		// software enable only counts in mode 01
		swd = 1'b0;
		swwr = 1'b1;
		@(negedge clk_i);
		swwr = 1'b0;
		@(negedge clk_i);
		chk({swen, mon}, 2'h1);
		cfg.brownout_mode_cfg = rss_pkg::BOR_MODE_SW;
		repeat (2) @(negedge clk_i);
		chk({mon, brdy}, 2'h0);
		swd = 1'b1;
		swwr = 1'b1;
		@(negedge clk_i);
		swwr = 1'b0;
		repeat (2) @(negedge clk_i);
		chk({mon, brdy}, 2'h3);
		cfg.brownout_mode_cfg = rss_pkg::BOR_MODE_OFF;
		repeat (2) @(negedge clk_i);
		chk({mon, run}, 2'h1);
		cfg.brownout_mode_cfg = rss_pkg::BOR_MODE_ON;
		// pin disabled: pull-up follows software
		{cfg.low_voltage_program_cfg, cfg.master_clear_cfg} = 2'h0;
		repeat (2) @(negedge clk_i);
		chk({mce, pup}, 2'h0);
		pu = 1'b1;
		repeat (2) @(negedge clk_i);
		chk({mce, pup}, 2'h1);
		$display("brown-out and pin control done");
	endtask : t_bor
	task complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		t_cold();
		t_instr();
		t_pin();
		t_bor();
		complete_run();
	end
endmodule : reset_source_and_startup_seq_bench
`default_nettype wire
